//--- verilog/usbimc_map.svh
/*
  Register map, field positions and reset values of the USB interrupt
  mask and clear block.
  Assumes a byte-wide register port with 16-bit CPU addresses.
*/
`ifndef USBIMC_MAP_SVH
`define USBIMC_MAP_SVH

// byte addresses of the registers
`define USBIMC_A_BI_MASK 16'hFF39
`define USBIMC_A_BO_MASK 16'hFF3A
`define USBIMC_A_SI_MASK 16'hFF3B
`define USBIMC_A_EVT_STS 16'hFF3C
`define USBIMC_A_EVT_MSK 16'hFF3D
`define USBIMC_A_BEV_CLR 16'hFF4A
`define USBIMC_A_CEP_CLR 16'hFF4B
`define USBIMC_A_BI_CLR 16'hFF4C

// implemented bits of each register
`define USBIMC_BI_VALID 8'h30
`define USBIMC_BO_VALID 8'h0F
`define USBIMC_SI_VALID 8'h20
`define USBIMC_BEV_VALID 8'hC7
`define USBIMC_CEP_VALID 8'h7F
`define USBIMC_EVT_VALID 2'h3

// field positions
`define USBIMC_BI_TOKEN_BIT 5
`define USBIMC_BI_DATA_BIT 4
`define USBIMC_SET_IFACE_BIT 5
`define USBIMC_EVT_SI_CHG 0
`define USBIMC_EVT_LINE_B 1

// reset and read-back values
`define USBIMC_MASK_RST 8'h00
`define USBIMC_CLR_READ 8'hFF
`define USBIMC_UNMAPPED 8'h00

`endif

//--- verilog/usbimc_pkg.sv
/*
  Types shared by the USB interrupt mask and clear block.
  Assumes the map header supplies all numeric constants.
*/
package usbimc_pkg;
  typedef logic [7:0] usbimc_byte_t;

  // state of one mask register
  typedef struct packed {
    usbimc_byte_t val;
  } usbimc_mask_s;

  // state of one clear register: only its outgoing pulses
  typedef struct packed {
    usbimc_byte_t pulse;
  } usbimc_clr_s;

  // state of the top level
  typedef struct packed {
    usbimc_byte_t rd_data;
    logic line_b;
    logic line_c;
    logic irq;
    logic [1:0] evt_sts;
    logic [1:0] evt_msk;
    usbimc_byte_t si_prev;
    logic si_prev_vld;
  } usbimc_state_s;
endpackage

//--- verilog/usbimc_mask_reg.sv
/*
  One byte-wide read/write mask register; unused bits are held at zero.
  Assumes a single-cycle write strobe from the register port.
*/
`timescale 1ns/1ns

module usbimc_mask_reg
  import usbimc_pkg::*;
#(
  parameter usbimc_byte_t VALID = 8'hFF,
  parameter usbimc_byte_t RESET = 8'h00
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire usbimc_byte_t wr_data,
  output usbimc_byte_t value
);
  usbimc_mask_s st_ff;
  usbimc_mask_s nxt_st;

  // whole-byte write; unused positions never store a one
  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.val = wr_data & VALID;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{val: RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.val;
endmodule // usbimc_mask_reg

//--- verilog/usbimc_clear_reg.sv
/*
  One write-only clear register: a zero written to a live bit gives a
  one-cycle clear pulse toward the status register; nothing is stored.
  Assumes the status register clears its bit on the pulse.
*/
`timescale 1ns/1ns

module usbimc_clear_reg
  import usbimc_pkg::*;
#(
  parameter usbimc_byte_t VALID = 8'hFF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire usbimc_byte_t wr_data,
  input wire usbimc_byte_t allow,
  output usbimc_byte_t pulse
);
  usbimc_clr_s st_ff;
  usbimc_clr_s nxt_st;
  usbimc_byte_t hit;

  // per bit: zero written, bit implemented and source supported
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign hit[i] = wr_en & ~wr_data[i] & VALID[i] & allow[i];
  end

  // pulses last one cycle, so the register always reads as all ones
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse = hit;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{pulse: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse = st_ff.pulse;
endmodule // usbimc_clear_reg

//--- verilog/usbimc_top.sv
/*
  Interrupt mask and clear logic of a USB function controller: masks
  for the bulk-in, bulk-out and set-interface sources, clear pulses
  for the bus-event, control-endpoint and bulk-in status registers,
  and the two request lines that the masked sources drive.
  Assumes the status registers sit in the same clock domain and clear
  a latched bit on a one-cycle pulse; endpoint support levels come from
  the endpoint enable configuration and interface setting logic.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "usbimc_map.svh"

module usbimc_top
  import usbimc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire usbimc_byte_t wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output usbimc_byte_t rd_data,
  input wire logic ep1_supported,
  input wire logic ep2_supported,
  input wire usbimc_byte_t bulk_in_status,
  input wire usbimc_byte_t bulk_out_status,
  input wire usbimc_byte_t set_iface_status,
  output usbimc_byte_t bus_event_clr,
  output usbimc_byte_t ctrl_ep_clr,
  output usbimc_byte_t bulk_in_clr,
  output logic usb_irq_line_b,
  output logic usb_irq_line_c,
  output logic usb_irq_out
);
  usbimc_state_s st_ff;
  usbimc_state_s nxt_st;
  usbimc_byte_t bi_mask;
  usbimc_byte_t bo_mask;
  usbimc_byte_t si_mask;
  usbimc_byte_t bi_allow;
  logic ep_both;
  logic bi_src;
  logic bo_src;
  logic si_chg;
  logic wr_bi_mask;
  logic wr_bo_mask;
  logic wr_si_mask;
  logic wr_evt_sts;
  logic wr_evt_msk;
  logic wr_bev_clr;
  logic wr_cep_clr;
  logic wr_bi_clr;

  // address decode; the port never stalls, so decode is purely combinational
  assign wr_bi_mask = wr_en && (addr == `USBIMC_A_BI_MASK);
  assign wr_bo_mask = wr_en && (addr == `USBIMC_A_BO_MASK);
  assign wr_si_mask = wr_en && (addr == `USBIMC_A_SI_MASK);
  assign wr_evt_sts = wr_en && (addr == `USBIMC_A_EVT_STS);
  assign wr_evt_msk = wr_en && (addr == `USBIMC_A_EVT_MSK);
  assign wr_bev_clr = wr_en && (addr == `USBIMC_A_BEV_CLR);
  assign wr_cep_clr = wr_en && (addr == `USBIMC_A_CEP_CLR);
  assign wr_bi_clr = wr_en && (addr == `USBIMC_A_BI_CLR);

  // mask registers; stored value already has unused bits at zero
  usbimc_mask_reg #(
    .VALID(`USBIMC_BI_VALID),
    .RESET(`USBIMC_MASK_RST)
  ) u_bi_mask (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_bi_mask),
    .wr_data(wr_data),
    .value(bi_mask)
  );

  usbimc_mask_reg #(
    .VALID(`USBIMC_BO_VALID),
    .RESET(`USBIMC_MASK_RST)
  ) u_bo_mask (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_bo_mask),
    .wr_data(wr_data),
    .value(bo_mask)
  );

  usbimc_mask_reg #(
    .VALID(`USBIMC_SI_VALID),
    .RESET(`USBIMC_MASK_RST)
  ) u_si_mask (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_si_mask),
    .wr_data(wr_data),
    .value(si_mask)
  );

  // clear registers; status lives outside, only the pulses leave here
  assign bi_allow = {8{ep1_supported}};

  usbimc_clear_reg #(
    .VALID(`USBIMC_BEV_VALID)
  ) u_bev_clr (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_bev_clr),
    .wr_data(wr_data),
    .allow(8'hFF),
    .pulse(bus_event_clr)
  );

  usbimc_clear_reg #(
    .VALID(`USBIMC_CEP_VALID)
  ) u_cep_clr (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_cep_clr),
    .wr_data(wr_data),
    .allow(8'hFF),
    .pulse(ctrl_ep_clr)
  );

  usbimc_clear_reg #(
    .VALID(`USBIMC_BI_VALID)
  ) u_bi_clr (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(wr_bi_clr),
    .wr_data(wr_data),
    .allow(bi_allow),
    .pulse(bulk_in_clr)
  );

  // masked sources; an unsupported endpoint contributes nothing at all
  assign bi_src = ep1_supported && |(bulk_in_status & ~bi_mask & `USBIMC_BI_VALID);
  assign bo_src = ep2_supported && |(bulk_out_status & ~bo_mask & `USBIMC_BO_VALID);
  assign ep_both = ep1_supported && ep2_supported;
  // first sample after reset only arms the compare, so straps do not fire
  assign si_chg = st_ff.si_prev_vld && (set_iface_status != st_ff.si_prev);

  // next-state of request lines, event flags and read data
  always_comb begin
    nxt_st = st_ff;
    nxt_st.si_prev = set_iface_status;
    nxt_st.si_prev_vld = 1'h1;
    nxt_st.line_b = bi_src || bo_src;
    // software clears by writing one; a new event in that cycle wins
    if (wr_evt_sts) begin
      nxt_st.evt_sts = st_ff.evt_sts & ~wr_data[1:0];
    end
    if (si_chg) begin
      nxt_st.evt_sts[`USBIMC_EVT_SI_CHG] = 1'h1;
    end
    if (nxt_st.line_b && !st_ff.line_b) begin
      nxt_st.evt_sts[`USBIMC_EVT_LINE_B] = 1'h1;
    end
    if (wr_evt_msk) begin
      nxt_st.evt_msk = wr_data[1:0] & `USBIMC_EVT_VALID;
    end
    // line c follows the status bit or a pending change, both maskable
    nxt_st.line_c = ep_both && !si_mask[`USBIMC_SET_IFACE_BIT] &&
      (set_iface_status[`USBIMC_SET_IFACE_BIT] || nxt_st.evt_sts[`USBIMC_EVT_SI_CHG]);
    nxt_st.irq = |(nxt_st.evt_sts & ~nxt_st.evt_msk);
    // read data stands only in the cycle after the read strobe
    nxt_st.rd_data = 8'h00;
    if (rd_en) begin
      case (addr)
        `USBIMC_A_BI_MASK: nxt_st.rd_data = bi_mask;
        `USBIMC_A_BO_MASK: nxt_st.rd_data = bo_mask;
        `USBIMC_A_SI_MASK: nxt_st.rd_data = si_mask;
        `USBIMC_A_EVT_STS: nxt_st.rd_data = {6'h00, st_ff.evt_sts};
        `USBIMC_A_EVT_MSK: nxt_st.rd_data = {6'h00, st_ff.evt_msk};
        `USBIMC_A_BEV_CLR: nxt_st.rd_data = `USBIMC_CLR_READ;
        `USBIMC_A_CEP_CLR: nxt_st.rd_data = `USBIMC_CLR_READ;
        `USBIMC_A_BI_CLR: nxt_st.rd_data = `USBIMC_CLR_READ;
        default: nxt_st.rd_data = `USBIMC_UNMAPPED;
      endcase
    end
  end

  // single register stage for all top-level state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd_data;
  assign usb_irq_line_b = st_ff.line_b;
  assign usb_irq_line_c = st_ff.line_c;
  assign usb_irq_out = st_ff.irq;

  // checks on the observable behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // mask reads return the stored byte with unused bits at zero
  property p_mask_read;
    rd_en && (addr == `USBIMC_A_BO_MASK) |=> rd_data == $past(bo_mask) && rd_data[7:4] == 4'h0;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read back wrong");

  // unmasked bulk-in token raises line b one edge later
  property p_bi_pass;
    ep1_supported && bulk_in_status[`USBIMC_BI_TOKEN_BIT] && !bi_mask[`USBIMC_BI_TOKEN_BIT]
      |=> usb_irq_line_b;
  endproperty
  a_bi_pass: assert property (p_bi_pass)
    else $error("unmasked bulk-in source did not raise line b");

  // fully masked bulk-in sources keep line b low
  property p_bi_block;
    (bi_mask[5:4] == 2'h3) && !bo_src |=> !usb_irq_line_b;
  endproperty
  a_bi_block: assert property (p_bi_block)
    else $error("masked bulk-in source reached line b");

  // fully masked bulk-out sources keep line b low
  property p_bo_block;
    (bo_mask[3:0] == 4'hF) && !bi_src |=> !usb_irq_line_b;
  endproperty
  a_bo_block: assert property (p_bo_block)
    else $error("masked bulk-out source reached line b");

  // set-interface mask holds line c low
  property p_si_block;
    si_mask[`USBIMC_SET_IFACE_BIT] |=> !usb_irq_line_c;
  endproperty
  a_si_block: assert property (p_si_block)
    else $error("masked set-interface source reached line c");

  // unsupported endpoint 1: no bulk-in clear pulse
  property p_bi_unsup;
    !ep1_supported && wr_bi_clr |=> bulk_in_clr == 8'h00;
  endproperty
  a_bi_unsup: assert property (p_bi_unsup)
    else $error("bulk-in clear acted on unsupported endpoint");

  // unsupported endpoint 2 with no bulk-in source: line b stays low
  property p_bo_unsup;
    !ep2_supported && !bi_src |=> !usb_irq_line_b;
  endproperty
  a_bo_unsup: assert property (p_bo_unsup)
    else $error("bulk-out source active on unsupported endpoint");

  // set-interface request needs both endpoint groups
  property p_si_unsup;
    !ep_both |=> !usb_irq_line_c;
  endproperty
  a_si_unsup: assert property (p_si_unsup)
    else $error("line c active without endpoint support");

  // clear registers always read as all ones
  property p_clr_read;
    rd_en && (addr == `USBIMC_A_BEV_CLR || addr == `USBIMC_A_CEP_CLR ||
      addr == `USBIMC_A_BI_CLR) |=> rd_data == `USBIMC_CLR_READ;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("clear register did not read FFH");

  // zeros written give pulses on implemented bits, for exactly one cycle
  property p_bev_pulse;
    wr_bev_clr |=> bus_event_clr == (~$past(wr_data) & `USBIMC_BEV_VALID)
      ##1 (bus_event_clr == 8'h00 || $past(wr_bev_clr));
  endproperty
  a_bev_pulse: assert property (p_bev_pulse)
    else $error("bus-event clear pulse wrong");

  // control-endpoint clear, bit 7 never pulses
  property p_cep_pulse;
    wr_cep_clr |=> ctrl_ep_clr == (~$past(wr_data) & `USBIMC_CEP_VALID) && !ctrl_ep_clr[7];
  endproperty
  a_cep_pulse: assert property (p_cep_pulse)
    else $error("control-endpoint clear pulse wrong");

  // bulk-in clear of token bit 5, taken even while the source is pending
  property p_bi_pulse;
    wr_bi_clr && ep1_supported && !wr_data[`USBIMC_BI_TOKEN_BIT]
      |=> bulk_in_clr[`USBIMC_BI_TOKEN_BIT];
  endproperty
  a_bi_pulse: assert property (p_bi_pulse)
    else $error("bulk-in token clear missing");

  // a change of set-interface status raises line c next edge
  property p_si_change;
    si_chg && ep_both && !si_mask[`USBIMC_SET_IFACE_BIT] |=> usb_irq_line_c;
  endproperty
  a_si_change: assert property (p_si_change)
    else $error("set-interface change did not raise line c");

  // event flag survives a clear written in the same cycle as the event
  property p_evt_set_wins;
    si_chg |=> st_ff.evt_sts[`USBIMC_EVT_SI_CHG];
  endproperty
  a_evt_set_wins: assert property (p_evt_set_wins)
    else $error("event flag lost against clear");
endmodule // usbimc_top

//--- test/usbimc_top_tb_top.sv
/*
  Self-checking bench for the USB interrupt mask and clear block.
  Assumes the byte register port of usbimc_top, one 100 MHz clock and
  status inputs that the bench drives in place of the status registers.
*/
`timescale 1ns/1ns

module usbimc_top_tb_top
  import usbimc_pkg::*;
;
  typedef struct packed {
    logic e1;
    logic e2;
    usbimc_byte_t bi;
    usbimc_byte_t bo;
    usbimc_byte_t mbi;
    usbimc_byte_t mbo;
    logic exp;
  } usbimc_row_s;

  logic clock;
  logic arst_n;
  logic [15:0] addr;
  usbimc_byte_t wr_data, rd_data, bi_sts, bo_sts, si_sts, d;
  usbimc_byte_t bev_clr, cep_clr, bi_clr, s_bev, s_cep, s_bi;
  logic wr_en, rd_en, ep1, ep2, line_b, line_c, irq_out;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  usbimc_row_s r;

  // line b cases: support, sources, masks, expected line
  usbimc_row_s rows[10] = '{
    '{1'h1, 1'h1, 8'h20, 8'h00, 8'h00, 8'h00, 1'h1},
    '{1'h1, 1'h1, 8'h20, 8'h00, 8'h20, 8'h00, 1'h0},
    '{1'h1, 1'h1, 8'h10, 8'h00, 8'h20, 8'h00, 1'h1},
    '{1'h1, 1'h1, 8'h10, 8'h00, 8'hFF, 8'h00, 1'h0},
    '{1'h0, 1'h1, 8'h30, 8'h00, 8'h00, 8'h00, 1'h0},
    '{1'h1, 1'h1, 8'h00, 8'h08, 8'h00, 8'h07, 1'h1},
    '{1'h1, 1'h1, 8'h00, 8'h08, 8'h00, 8'hF8, 1'h0},
    '{1'h1, 1'h1, 8'h00, 8'h01, 8'h00, 8'h0E, 1'h1},
    '{1'h1, 1'h0, 8'h00, 8'h0F, 8'h00, 8'h00, 1'h0},
    '{1'h1, 1'h1, 8'hCF, 8'hF0, 8'h30, 8'h0F, 1'h0}};

  // clear cases: address, data, ep1 support, expected {bev, cep, bi}
  logic [15:0] caddr[7] = '{16'hFF4A, 16'hFF4B, 16'hFF4C, 16'hFF4A, 16'hFF4B,
    16'hFF4C, 16'hFF4A};
  usbimc_byte_t cdat[7] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'hB8, 8'h00, 8'hFF};
  logic ce1[7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
  logic [23:0] cexp[7] = '{24'hC70000, 24'h007F00, 24'h000030, 24'h800000,
    24'h004700, 24'h000000, 24'h000000};

  usbimc_top uut (
    .clock(clock),
    .arst_n(arst_n),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .ep1_supported(ep1),
    .ep2_supported(ep2),
    .bulk_in_status(bi_sts),
    .bulk_out_status(bo_sts),
    .set_iface_status(si_sts),
    .bus_event_clr(bev_clr),
    .ctrl_ep_clr(cep_clr),
    .bulk_in_clr(bi_clr),
    .usb_irq_line_b(line_b),
    .usb_irq_line_c(line_c),
    .usb_irq_out(irq_out)
  );

  // free-running clock, 10 ns period
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // wait edges, then sample just after the last one
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one write cycle; clear pulses snapped in the cycle after
  task automatic wr(input logic [15:0] a, input usbimc_byte_t v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'h1;
    @(posedge clock);
    wr_en <= 1'h0;
    #1;
    s_bev = bev_clr;
    s_cep = cep_clr;
    s_bi = bi_clr;
  endtask

  // one read cycle; data only valid the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clock);
    rd_en <= 1'h0;
    #1;
    d = rd_data;
  endtask

  // hang guard, well above the fewer than 300 cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    arst_n = 1'h0;
    addr = 16'h0000;
    wr_data = 8'h00;
    wr_en = 1'h0;
    rd_en = 1'h0;
    ep1 = 1'h1;
    ep2 = 1'h1;
    bi_sts = 8'h00;
    bo_sts = 8'h00;
    si_sts = 8'h00;
    repeat (20) @(posedge clock);
    arst_n <= 1'h1;
    rd(16'hFF39); chk(d, 8'h00);
    rd(16'hFF3A); chk(d, 8'h00);
    rd(16'hFF3B); chk(d, 8'h00);
    rd(16'hFF40); chk(d, 8'h00);
    // masking of line b, read-back of masks with unused bits dropped
    foreach (rows[i]) begin
      r = rows[i];
      wr(16'hFF39, r.mbi);
      wr(16'hFF3A, r.mbo);
      @(posedge clock);
      ep1 <= r.e1;
      ep2 <= r.e2;
      bi_sts <= r.bi;
      bo_sts <= r.bo;
      w(2);
      chk({7'h00, line_b}, {7'h00, r.exp});
      rd(16'hFF39); chk(d, r.mbi & 8'h30);
      rd(16'hFF3A); chk(d, r.mbo & 8'h0F);
    end
    // event flag from line b: raise, mask, clear
    chk({7'h00, irq_out}, 8'h01);
    rd(16'hFF3C); chk(d, 8'h02);
    wr(16'hFF3D, 8'h02);
    w(2); chk({7'h00, irq_out}, 8'h00);
    rd(16'hFF3D); chk(d, 8'h02);
    wr(16'hFF3C, 8'h02);
    wr(16'hFF3D, 8'h00);
    w(2); chk({7'h00, irq_out}, 8'h00);
    rd(16'hFF3C); chk(d, 8'h00);
    // set-interface source, its change flag and its mask
    @(posedge clock);
    si_sts <= 8'h20;
    w(3); chk({7'h00, line_c}, 8'h01);
    rd(16'hFF3C); chk(d & 8'h01, 8'h01);
    wr(16'hFF3B, 8'hFF);
    rd(16'hFF3B); chk(d, 8'h20);
    w(2); chk({7'h00, line_c}, 8'h00);
    // drop the pending flag so only a fresh change can raise line c
    wr(16'hFF3C, 8'h01);
    wr(16'hFF3B, 8'h00);
    @(posedge clock);
    si_sts <= 8'h00;
    w(3); chk({7'h00, line_c}, 8'h01);
    wr(16'hFF3C, 8'h03);
    w(2); chk({7'h00, line_c}, 8'h00);
    @(posedge clock);
    si_sts <= 8'h20;
    ep2 <= 1'h0;
    w(3); chk({7'h00, line_c}, 8'h00);
    chk({7'h00, irq_out}, 8'h01);
    // clear of the change flag in the very cycle of a new change: set wins
    @(posedge clock);
    si_sts <= 8'h00;
    addr <= 16'hFF3C;
    wr_data <= 8'h01;
    wr_en <= 1'h1;
    @(posedge clock);
    wr_en <= 1'h0;
    rd(16'hFF3C); chk(d & 8'h01, 8'h01);
    // clear registers: pulses, ones ignored, gating, read-back
    bi_sts <= 8'h30;
    foreach (caddr[i]) begin
      @(posedge clock);
      ep1 <= ce1[i];
      wr(caddr[i], cdat[i]);
      chk(s_bev, cexp[i][23:16]);
      chk(s_cep, cexp[i][15:8]);
      chk(s_bi, cexp[i][7:0]);
      w(1); chk(bev_clr | cep_clr | bi_clr, 8'h00);
      rd(caddr[i]); chk(d, 8'hFF);
    end
    // second reset in mid-run brings masks and lines back to zero
    wr(16'hFF3A, 8'h0F);
    @(posedge clock);
    arst_n <= 1'h0;
    #1;
    chk({5'h00, line_b, line_c, irq_out}, 8'h00);
    repeat (2) @(posedge clock);
    arst_n <= 1'h1;
    rd(16'hFF3A); chk(d, 8'h00);
    report_and_stop();
  end
endmodule // usbimc_top_tb_top
